// [rtl/cpd_pkg.sv]
// Summary of operation
// - Hard reset or main power-up leaves Run state with every logical device inactive.
// - Strap is caught at hard reset falling edge or main power-up.
// - Strap low gives port 0x02E, strap high gives 0x04E.
// - Config port decodes at the address held in global indexes 0x26 and 0x27.
// - Byte 0x55 to the config port enters Configuration state, enabling index/data.
// - Byte 0xAA to the config port returns to Run state.
// - Index and data ports act only in Configuration state.
// - Index port sits at config port address, data port one above; both read/write.
// - Index 0x07 selects logical device; later indexes reach that device's registers.
// - Global registers are reachable whatever logical device is selected.
// - Only Run and Configuration states; Run accepts the entry key except during power-up blocking or while hard reset is held.
// - Writing one to bit 0 of index 0x02 soft-resets registers having soft defaults.
// - All host accesses ignored for 500 us after main power-up.
package cpd_pkg;

  localparam int CLK_MHZ          = 200;
  localparam int POR_BLOCK_US     = 500;
  localparam int POR_BLOCK_CYCLES = POR_BLOCK_US * CLK_MHZ;

  localparam logic [7:0]  KEY_ENTER       = 8'h55;
  localparam logic [7:0]  KEY_EXIT        = 8'hAA;
  localparam logic [7:0]  IDX_CTRL        = 8'h02;
  localparam logic [7:0]  IDX_RSVD        = 8'h03;
  localparam logic [7:0]  IDX_CHIP_ID     = 8'h20;
  localparam logic [7:0]  IDX_CHIP_REV    = 8'h21;
  localparam logic [7:0]  IDX_PORT_LO     = 8'h26;
  localparam logic [7:0]  IDX_PORT_HI     = 8'h27;
  localparam int          CTRL_SOFT_BIT   = 0;
  localparam logic [7:0]  PORT_LO_STRAP0  = 8'h2E;
  localparam logic [7:0]  PORT_LO_STRAP1  = 8'h4E;
  localparam logic [7:0]  PORT_HI_DEFAULT = 8'h00;
  localparam logic [15:0] DATA_PORT_STEP  = 16'h0001;
  localparam logic [7:0]  LDN_FLOPPY      = 8'h00;
  localparam logic [7:0]  READ_ZERO       = 8'h00;

  localparam int NUM_REGS   = 19;
  localparam int LDN_ENTRY  = 0;
  localparam int FACT_ENTRY = 10;
  // Entry 0 is rightmost
  localparam logic [NUM_REGS-1:0][7:0] REG_INDEX = {
    8'hF4, 8'hF2, 8'hF1, 8'hF0, 8'h74, 8'h70, 8'h61, 8'h60, 8'h30,
    8'h2F, 8'h2E, 8'h2D, 8'h2C, 8'h2B, 8'h2A, 8'h24, 8'h23, 8'h22, 8'h07};
  localparam logic [NUM_REGS-1:0][7:0] REG_DEFAULT = {
    8'h00, 8'hFF, 8'h00, 8'h0E, 8'h02, 8'h06, 8'hF0, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
  localparam logic [NUM_REGS-1:0] REG_GLOBAL = 19'h003FF;
  localparam logic [NUM_REGS-1:0] REG_HARD   = 19'h7FC0F;
  localparam logic [NUM_REGS-1:0] REG_SOFT   = 19'h07C03;

  typedef enum logic {
    CPD_RUN    = 1'b0,
    CPD_CONFIG = 1'b1
  } cpd_state_t;

endpackage

// [rtl/cpd_sync.sv]
`timescale 1ns/10ps
module cpd_sync
  import cpd_pkg::*;
#(
  parameter int               Width     = 1,
  parameter logic [Width-1:0] ResetVal  = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [Width-1:0] asyncIn,
  output logic      [Width-1:0] syncOut_r
);

  logic [Width-1:0] stage1_r;

  // Checked while elaborating, not at run time
  if (Width < 1) begin : gBadWidth
    $error("cpd_sync: Width must be positive");
  end

  // Stage one feeds stage two only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r  <= ResetVal;
      syncOut_r <= ResetVal;
    end else begin
      stage1_r  <= asyncIn;
      syncOut_r <= stage1_r;
    end
  end

endmodule

// [rtl/cpd_reg_bank.sv]
`timescale 1ns/10ps
module cpd_reg_bank
  import cpd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       hardClr,
  input  wire logic       vtrClr,
  input  wire logic       softClr,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  input  wire logic [7:0] accIndex,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData_r,
  output logic            rdHit_r,
  output logic            floppyActive_r
);

  logic [7:0]          regVal_r [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic [7:0]          rdData_nxt;

  for (genvar g = 0; g < NUM_REGS; g++) begin : gEntry
    // Globals ignore device selection others follow it
    assign hit[g] = (accIndex == REG_INDEX[g]) &&
                    (REG_GLOBAL[g] || (regVal_r[LDN_ENTRY] == LDN_FLOPPY));

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        regVal_r[g] <= REG_DEFAULT[g];
      end else if (vtrClr || (hardClr && REG_HARD[g])) begin
        regVal_r[g] <= REG_DEFAULT[g];
      end else if (softClr && REG_SOFT[g]) begin
        regVal_r[g] <= REG_DEFAULT[g];
      end else if (wrEn && hit[g]) begin
        regVal_r[g] <= wrData;
      end
    end
  end

  always_comb begin
    rdData_nxt = READ_ZERO;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (hit[i]) rdData_nxt = rdData_nxt | regVal_r[i];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_r <= READ_ZERO;
      rdHit_r  <= 1'b0;
    end else if (rdEn) begin
      rdData_r <= rdData_nxt;
      rdHit_r  <= |hit;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      floppyActive_r <= 1'b0;
    end else begin
      floppyActive_r <= regVal_r[FACT_ENTRY][0];
    end
  end

endmodule

// [rtl/cpd_top.sv]
`timescale 1ns/10ps
module cpd_top
  import cpd_pkg::*;
#(
  parameter int         PorBlockCycles = POR_BLOCK_CYCLES,
  parameter logic [7:0] ChipId         = 8'hA5,  // Arbitrary value
  parameter logic [7:0] ChipRev        = 8'h01   // Arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        hostHardReset_n,
  input  wire logic        standbyPowerOnReset_n,
  input  wire logic        sharedGeneralPin,
  input  wire logic        ioStrobe,
  input  wire logic        ioWrite,
  input  wire logic [15:0] ioAddr,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData_r,
  output logic             ioAck_r,
  output logic             configMode_r,
  output logic             accessBlocked_r,
  output logic             floppyEnable
);

  localparam int CntW = $clog2(PorBlockCycles + 1);

  // Checked while elaborating, not at run time
  if (PorBlockCycles < 3) begin : gBadPor
    $error("cpd_top: PorBlockCycles must be at least 3");
  end

  cpd_state_t   state_r;
  logic [2:0]   pinSync;
  logic         hardSync;
  logic         vtrSync;
  logic         strapSync;
  logic         hardPrev_r;
  logic         hardActive;
  logic         hardFall;
  logic         vtrActive;
  logic         strapLatch_r;
  logic         strapNow;
  logic [CntW-1:0] porCnt_r;
  logic         porBusy;
  logic [7:0]   index_r;
  logic [7:0]   portLo_r;
  logic [7:0]   portHi_r;
  logic [15:0]  configBase;
  logic [15:0]  dataAddr;
  logic         hitIndex;
  logic         hitData;
  logic         inCfg;
  logic         take;
  logic         cfgPortWr;
  logic         idxWr;
  logic         idxRd;
  logic         dataWr;
  logic         dataRd;
  logic         decoded;
  logic         softClr_r;
  logic         pend_r;
  logic         pendRead_r;
  logic         pendMain_r;
  logic [7:0]   mainRd_r;
  logic [7:0]   mainRd_nxt;
  logic [7:0]   bankRd;
  logic         bankHit;
  logic [7:0]   defaultPortLo;

  // Pins from outside the clock domain
  cpd_sync #(
    .Width    (3),
    .ResetVal (3'b011)
  ) uSync (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .asyncIn   ({sharedGeneralPin, standbyPowerOnReset_n, hostHardReset_n}),
    .syncOut_r (pinSync)
  );

  assign hardSync  = pinSync[0];
  assign vtrSync   = pinSync[1];
  assign strapSync = pinSync[2];

  assign hardActive = !hardSync;
  assign vtrActive  = !vtrSync;
  assign hardFall   = hardPrev_r && !hardSync;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hardPrev_r <= 1'b1;
    end else begin
      hardPrev_r <= hardSync;
    end
  end

  // Power-up blocking window
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      porCnt_r <= CntW'(PorBlockCycles);
    end else if (porCnt_r != '0) begin
      porCnt_r <= porCnt_r - CntW'(1);
    end
  end

  assign porBusy = (porCnt_r != '0);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      accessBlocked_r <= 1'b1;
    end else begin
      accessBlocked_r <= porBusy || hardActive;
    end
  end

  // Strap caught through the whole power-up window so the sync has settled
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapLatch_r <= 1'b0;
    end else if (porBusy || hardFall) begin
      strapLatch_r <= strapSync;
    end
  end

  assign strapNow      = (porBusy || hardFall) ? strapSync : strapLatch_r;
  assign defaultPortLo = strapNow ? PORT_LO_STRAP1 : PORT_LO_STRAP0;

  // Address decode
  assign configBase = {portHi_r, portLo_r};
  assign dataAddr   = configBase + DATA_PORT_STEP;
  assign hitIndex   = (ioAddr == configBase);
  assign hitData    = (ioAddr == dataAddr);
  assign inCfg      = (state_r == CPD_CONFIG);

  // Accesses are dropped during power-up and while hard reset is held
  assign take = ioStrobe && !pend_r && !porBusy && !hardActive;

  assign cfgPortWr = take && ioWrite && hitIndex;
  assign idxWr     = cfgPortWr && inCfg && (ioWrData != KEY_EXIT);
  assign idxRd     = take && !ioWrite && hitIndex && inCfg;
  assign dataWr    = take && ioWrite && hitData && inCfg;
  assign dataRd    = take && !ioWrite && hitData && inCfg;
  assign decoded   = cfgPortWr || idxRd || dataWr || dataRd;

  // Two-state controller
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CPD_RUN;
    end else if (hardActive) begin
      state_r <= CPD_RUN;
    end else if (cfgPortWr) begin
      unique case (state_r)
        CPD_RUN: begin
          // Other bytes in Run are dropped
          if (ioWrData == KEY_ENTER) state_r <= CPD_CONFIG;
        end
        CPD_CONFIG: begin
          if (ioWrData == KEY_EXIT) state_r <= CPD_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      configMode_r <= 1'b0;
    end else begin
      configMode_r <= (state_r == CPD_CONFIG);
    end
  end

  // Index port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      index_r <= READ_ZERO;
    end else if (idxWr) begin
      index_r <= ioWrData;
    end
  end

  // Relocatable config port address
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      portLo_r <= PORT_LO_STRAP0;
    end else if (porBusy || hardActive) begin
      portLo_r <= defaultPortLo;
    end else if (dataWr && (index_r == IDX_PORT_LO)) begin
      portLo_r <= ioWrData;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      portHi_r <= PORT_HI_DEFAULT;
    end else if (porBusy || hardActive) begin
      portHi_r <= PORT_HI_DEFAULT;
    end else if (dataWr && (index_r == IDX_PORT_HI)) begin
      portHi_r <= ioWrData;
    end
  end

  // Write-only control; no storage, one-cycle soft reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      softClr_r <= 1'b0;
    end else begin
      softClr_r <= dataWr && (index_r == IDX_CTRL) && ioWrData[CTRL_SOFT_BIT];
    end
  end

  // Registers outside the table
  always_comb begin
    mainRd_nxt = READ_ZERO;
    if (idxRd) begin
      mainRd_nxt = index_r;
    end else begin
      unique case (index_r)
        IDX_CHIP_ID:  mainRd_nxt = ChipId;
        IDX_CHIP_REV: mainRd_nxt = ChipRev;
        IDX_PORT_LO:  mainRd_nxt = portLo_r;
        IDX_PORT_HI:  mainRd_nxt = portHi_r;
        IDX_RSVD:     mainRd_nxt = READ_ZERO;
        default:      mainRd_nxt = READ_ZERO;
      endcase
    end
  end

  cpd_reg_bank uBank (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .hardClr        (hardActive),
    .vtrClr         (vtrActive),
    .softClr        (softClr_r),
    .wrEn           (dataWr),
    .rdEn           (take),
    .accIndex       (index_r),
    .wrData         (ioWrData),
    .rdData_r       (bankRd),
    .rdHit_r        (bankHit),
    .floppyActive_r (floppyEnable)
  );

  // Answer two cycles after the strobe; bank read data is registered
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r     <= 1'b0;
      pendRead_r <= 1'b0;
      pendMain_r <= 1'b0;
      mainRd_r   <= READ_ZERO;
    end else begin
      pend_r     <= decoded;
      pendRead_r <= idxRd || dataRd;
      pendMain_r <= idxRd;
      mainRd_r   <= mainRd_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ioAck_r <= 1'b0;
    end else begin
      ioAck_r <= pend_r;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ioRdData_r <= READ_ZERO;
    end else if (pend_r && pendRead_r) begin
      if (!pendMain_r && bankHit) begin
        ioRdData_r <= bankRd;
      end else begin
        ioRdData_r <= mainRd_r;
      end
    end else begin
      ioRdData_r <= READ_ZERO;
    end
  end

endmodule

// [verif/cpd_checker.sv]
`timescale 1ns/10ps
module cpd_checker
  import cpd_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       hostHardReset_n,
  input wire logic       ioStrobe,
  input wire logic       ioWrite,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData_r,
  input wire logic       ioAck_r,
  input wire logic       configMode_r,
  input wire logic       accessBlocked_r,
  input wire logic       floppyEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_ack_single: assert property (ioAck_r |=> !ioAck_r)
    else $error("ack wider than one cycle");
  a_ack_cause: assert property (ioAck_r |-> $past(ioStrobe, 2))
    else $error("ack without strobe");
  a_enter_key: assert property ($rose(configMode_r) |->
    ioAck_r && $past(ioWrite && ioWrData == KEY_ENTER, 2))
    else $error("config entered without key");
  a_exit_key: assert property ($fell(configMode_r) && !accessBlocked_r |->
    ioAck_r && $past(ioWrite && ioWrData == KEY_EXIT, 2))
    else $error("config left without key");
  a_run_read: assert property (!configMode_r && ioStrobe && !ioWrite |-> ##2 !ioAck_r)
    else $error("read acked in run");
  a_idle_zero: assert property (!ioAck_r |-> ioRdData_r == 8'h00)
    else $error("read data outside ack");
  a_data_config: assert property (ioAck_r && ioRdData_r != 8'h00 |-> configMode_r)
    else $error("data returned in run");
  a_blocked_refuse: assert property (ioStrobe ##1 accessBlocked_r |=> !ioAck_r)
    else $error("access taken while blocked");
  a_hard_reset: assert property (!hostHardReset_n [*6] |->
    !configMode_r && !floppyEnable && accessBlocked_r)
    else $error("hard reset not applied");
endmodule

bind cpd_top cpd_checker i_chk (.sys_clk, .reset_n, .hostHardReset_n, .ioStrobe,
  .ioWrite, .ioWrData, .ioRdData_r, .ioAck_r, .configMode_r, .accessBlocked_r,
  .floppyEnable);

// [verif/cpd_host.sv]
`timescale 1ns/10ps
module cpd_host (
  input  wire logic        sys_clk,
  output logic             ioStrobe,
  output logic             ioWrite,
  output logic      [15:0] ioAddr,
  output logic      [7:0]  ioWrData,
  input  wire logic [7:0]  ioRdData_r,
  input  wire logic        ioAck_r
);
  initial begin
    ioStrobe = 1'h0;
    ioWrite  = 1'h0;
    ioAddr   = 16'h0000;
    ioWrData = 8'h00;
  end

  // Two idle edges after each strobe keep the spacing legal
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic ack, output logic [7:0] q);
    @(posedge sys_clk);
    ioStrobe <= 1'h1;
    ioWrite  <= w;
    ioAddr   <= a;
    ioWrData <= d;
    @(posedge sys_clk);
    ioStrobe <= 1'h0;
    ioAddr   <= ~a; // Released lines must not echo the last value
    ioWrData <= ~d;
    @(posedge sys_clk);
    @(negedge sys_clk);
    ack = ioAck_r;
    q   = ioRdData_r;
  endtask
endmodule

// [verif/cpd_top_test.sv]
`timescale 1ns/10ps
module cpd_top_test
  import cpd_pkg::*;
;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
  localparam logic [7:0] CHIP_ID  = 8'h3C;  // Arbitrary value
  localparam logic [7:0] CHIP_REV = 8'h07;  // Arbitrary value
  logic        sys_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        hostHardReset_n = 1'h1;
  logic        standbyPowerOnReset_n = 1'h1;
  logic        sharedGeneralPin = 1'h1;
  logic        ioStrobe, ioWrite, ioAck_r, configMode_r, accessBlocked_r, floppyEnable;
  logic [15:0] ioAddr;
  logic [15:0] base;
  logic [7:0]  ioWrData, ioRdData_r;
  logic [7:0]  dIdx [8] = '{8'h24, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF2, 8'h2A};
  logic [7:0]  dVal [8] = '{8'h04, 8'h03, 8'hF0, 8'h06, 8'h02, 8'h0E, 8'hFF, 8'h00};
  int          miscompares = 0;
  int          cmp_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  cpd_top #(.PorBlockCycles(20), .ChipId(CHIP_ID), .ChipRev(CHIP_REV)) i_dut (
    .sys_clk, .reset_n, .hostHardReset_n, .standbyPowerOnReset_n, .sharedGeneralPin,
    .ioStrobe, .ioWrite, .ioAddr, .ioWrData, .ioRdData_r, .ioAck_r, .configMode_r,
    .accessBlocked_r, .floppyEnable);
  cpd_host i_host (.sys_clk, .ioStrobe, .ioWrite, .ioAddr, .ioWrData, .ioRdData_r,
    .ioAck_r);

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic ea);
    logic       ack;
    logic [7:0] q;
    i_host.xfer(1'h1, a, d, ack, q);
    `CHK("write ack", ea, ack)
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic ea);
    logic       ack;
    logic [7:0] q;
    i_host.xfer(1'h0, a, 8'h00, ack, q);
    `CHK("read ack", ea, ack)
    `CHK("read data", e, q)
  endtask

  task automatic rw(input logic [7:0] idx, input logic [7:0] d);
    wr(base, idx, 1'h1);
    wr(base + 16'h0001, d, 1'h1);
  endtask

  task automatic rr(input logic [7:0] idx, input logic [7:0] e);
    wr(base, idx, 1'h1);
    rd(base + 16'h0001, e, 1'h1);
  endtask

  task automatic wait_ready;
    for (int i = 0; i < 200 && accessBlocked_r !== 1'h0; i++) @(negedge sys_clk);
    `CHK("unblocked", 1'h0, accessBlocked_r)
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    base = 16'h004E;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(negedge sys_clk);
    `CHK("blocked", 1'h1, accessBlocked_r)
    wr(base, KEY_ENTER, 1'h0);
    wait_ready();
    `CHK("run", 1'h0, configMode_r)
    `CHK("floppy", 1'h0, floppyEnable)
    $display("test power-up done");
    rd(base, 8'h00, 1'h0);
    rd(base + 16'h0001, 8'h00, 1'h0);
    wr(base + 16'h0001, 8'h07, 1'h0);
    wr(base, 8'h12, 1'h1);
    `CHK("run", 1'h0, configMode_r)
    wr(base, KEY_ENTER, 1'h1);
    `CHK("config", 1'h1, configMode_r)
    $display("test entry done");
    wr(base, 8'h07, 1'h1);
    rd(base, 8'h07, 1'h1);
    wr(base + 16'h0001, LDN_FLOPPY, 1'h1);
    rw(8'h30, 8'h01);
    `CHK("floppy", 1'h1, floppyEnable)
    for (int i = 0; i < 8; i++) rr(dIdx[i], dVal[i]);
    rr(8'h03, 8'h00);
    rw(8'h20, 8'hFF);
    rr(8'h20, CHIP_ID);
    rr(8'h21, CHIP_REV);
    rw(8'h07, 8'h05);
    rr(8'h24, 8'h04);
    $display("test registers done");
    rw(8'h22, 8'h33);
    rw(8'h23, 8'h5A);
    rw(8'h02, 8'h01);
    rr(8'h07, 8'h00);
    rr(8'h22, 8'h00);
    rr(8'h23, 8'h5A);
    `CHK("floppy", 1'h0, floppyEnable)
    $display("test soft reset done");
    rw(8'h30, 8'h01);
    rw(8'h2A, 8'hA5);
    rw(8'h27, 8'h00);
    rw(8'h26, 8'h60);
    base = 16'h0060;
    rr(8'h26, 8'h60);
    wr(16'h004E, KEY_EXIT, 1'h0);
    wr(base, KEY_EXIT, 1'h1);
    `CHK("run", 1'h0, configMode_r)
    rd(base + 16'h0001, 8'h00, 1'h0);
    $display("test relocate done");
    sharedGeneralPin <= 1'h0;
    repeat (4) @(posedge sys_clk);
    hostHardReset_n <= 1'h0;
    repeat (5) @(posedge sys_clk);
    sharedGeneralPin <= 1'h1;
    repeat (5) @(posedge sys_clk);
    hostHardReset_n <= 1'h1;
    wait_ready();
    `CHK("floppy", 1'h0, floppyEnable)
    base = 16'h002E;
    wr(base, KEY_ENTER, 1'h1);
    rr(8'h26, 8'h2E);
    rr(8'h27, 8'h00);
    rr(8'h2A, 8'hA5);
    rw(8'h24, 8'h07);
    standbyPowerOnReset_n <= 1'h0;
    repeat (4) @(posedge sys_clk);
    standbyPowerOnReset_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rr(8'h24, 8'h04);
    `CHK("config", 1'h1, configMode_r)
    wr(base, KEY_EXIT, 1'h1);
    $display("test hard reset done");
    report_and_stop();
  end
endmodule
